// File: hw/lpc_cfg_pkg.sv
/*
 * Constants for the bridge miscellaneous configuration register bank:
 * offsets, field positions, reset values, write masks and decode windows.
 * Assumes a 32-bit dword-wide configuration access port.
 */
package lpc_cfg_pkg;

	// Dword offsets in configuration space
	localparam logic [7:0] OFF_EVENT_BLOCK_IO_BASE = 8'h4C;
	localparam logic [7:0] OFF_BUS_CLOCK_DRIVE     = 8'h54;
	localparam logic [7:0] OFF_CONTROL_IRQ_ROUTING = 8'h58;
	localparam logic [7:0] OFF_MISC_POWER_DECODE   = 8'h5C;
	localparam logic [7:0] OFF_SUBSYSTEM_ID        = 8'h2C;

	// Writable bit masks; all other bits are reserved and read zero, except misc bits 7:4, which read the memory strap
	localparam logic [31:0] MASK_EVENT_BLOCK = 32'h8000_FFC0;
	localparam logic [31:0] MASK_CLOCK_DRIVE = 32'h0006_003F;
	localparam logic [31:0] MASK_IRQ_ROUTING = 32'h0000_0007;
	localparam logic [31:0] MASK_MISC        = 32'h1F1F_1F0E;

	// Reset values (clock drive bit 0 comes from a strap)
	localparam logic [31:0] RST_EVENT_BLOCK  = 32'h0000_0000;
	localparam logic [31:0] RST_CLOCK_DRIVE  = 32'h0006_003E;
	localparam logic [31:0] RST_IRQ_ROUTING  = 32'h0000_0003;
	localparam logic [31:0] RST_MISC         = 32'h0000_0000;

	// Field positions
	localparam int EVT_EN_BIT      = 31;
	localparam int EVT_BASE_LSB    = 6;
	localparam int EVT_BASE_MSB    = 15;
	localparam int CLK_OUT2_EN_BIT = 18;
	localparam int CLK_OUT1_EN_BIT = 17;
	localparam int FREQ_SEL_BIT    = 28;
	localparam int TICK_CNT_LSB    = 24;
	localparam int BLK_TICK_LSB    = 16;
	localparam int BLK_IRQ_LSB     = 8;
	localparam int RANK_BIT        = 7;
	localparam int DENS_LSB        = 5;
	localparam int WIDTH_BIT       = 4;
	localparam int RTC_OFF_BIT     = 3;
	localparam int PIC_OFF_BIT     = 2;
	localparam int PIT_OFF_BIT     = 1;
	localparam int IO_ADDR_W       = 16;

	// Legacy decode windows (base, mask of don't-care bits)
	localparam logic [15:0] RTC_IO_BASE = 16'h0070;
	localparam logic [15:0] RTC_IO_MASK = 16'h0007;
	localparam logic [15:0] PIC_IO_BASE = 16'h0020;
	localparam logic [15:0] PIC_IO_MASK = 16'h0001;
	localparam logic [15:0] PIC2_IO_BASE = 16'h00A0;
	localparam logic [15:0] PIT_IO_BASE = 16'h0040;
	localparam logic [15:0] PIT_IO_MASK = 16'h0003;

	// Control interrupt routing codes
	typedef enum logic [2:0] {
		ROUTE_IRQ9  = 3'h0,
		ROUTE_IRQ10 = 3'h1,
		ROUTE_IRQ11 = 3'h2,
		ROUTE_OFF   = 3'h3,
		ROUTE_IRQ20 = 3'h4,
		ROUTE_IRQ21 = 3'h5,
		ROUTE_IRQ22 = 3'h6,
		ROUTE_IRQ23 = 3'h7
	} irq_route_t;

	// Sleep-state index: C2..C6 map to 0..4
	localparam int NUM_SLEEP = 5;

endpackage : lpc_cfg_pkg

// File: hw/tick_gatherer.sv
/*
 * Timer-tick gatherer: counts ticks while in a blocking sleep state and
 * pulses a break event when the programmed count is reached.
 * Assumes tick_in is a one-cycle pulse synchronous to clk_sys.
 */
`timescale 1ns/1ps
module tick_gatherer
	import lpc_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Control
	input  wire logic       gather_en,
	input  wire logic [3:0] tick_target,
	input  wire logic       tick_in,
	// Result
	output logic            break_pulse,
	output logic [4:0]      tick_count
);

	logic [4:0] tick_goal;

	// Field value 0 stands for 16 ticks
	assign tick_goal = (tick_target == 4'h0) ? 5'h10 : {1'b0, tick_target};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_count  <= 5'h00;
			break_pulse <= 1'b0;
		end else begin
			break_pulse <= 1'b0;
			if (!gather_en) begin
				tick_count <= 5'h00;
			end else if (tick_in) begin
				if (tick_count + 5'h01 >= tick_goal) begin
					tick_count  <= 5'h00;
					break_pulse <= 1'b1;
				end else begin
					tick_count <= tick_count + 5'h01;
				end
			end
		end
	end

endmodule : tick_gatherer

// File: hw/lpc_bridge_misc_config_regs.sv
/*
 * Miscellaneous configuration register bank of the low pin count bridge:
 * event-block I/O decode, clock output enables and drive, control interrupt
 * routing, and sleep-state tick/interrupt blocking plus legacy decode redirect.
 * Assumes single-cycle dword config accesses with byte enables on clk_sys.
 */
`timescale 1ns/1ps
module lpc_bridge_misc_config_regs
	import lpc_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Configuration access port
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic [31:0]      cfg_rdata,
	// Straps
	input  wire logic        strap_clk0_drive,
	input  wire logic [3:0]  strap_mem_id,
	input  wire logic        clock_fuse_blown,
	// Host I/O decode
	input  wire logic        io_req,
	input  wire logic [15:0] io_addr,
	output logic             general_event_block_hit,
	output logic             rtc_to_bus,
	output logic             pic_to_bus,
	output logic             pit_to_bus,
	// Clock outputs
	output logic             clk_out1_on,
	output logic             clk_out2_on,
	output logic [5:0]       clk_drive_q,
	output logic             bus_clk_full_rate,
	// Interrupt routing
	input  wire logic        system_control_interrupt,
	output logic [6:0]       control_irq_lines,
	// Power management
	input  wire logic [4:0]  sleep_state,
	input  wire logic        timer_tick,
	input  wire logic        irq_pending,
	output logic             timer_tick_out,
	output logic             irq_out,
	output logic             break_event
);

	logic [31:0] evt_base_q;
	logic [31:0] clk_drv_q;
	logic [31:0] route_q;
	logic [31:0] misc_q;
	logic [31:0] ssid_q;
	logic        ssid_locked_q;
	logic        strap_taken_q;
	logic [3:0]  mem_id_q;
	logic        irq_hold_q;
	logic [4:0]  irq_state_q;
	logic        irq_entry;
	logic        irq_release;
	logic        break_pulse;
	logic [4:0]  blk_tick;
	logic [4:0]  blk_irq;
	logic        tick_blocked;
	logic        irq_blocking;
	logic        gather_en;

	// Merge write data through byte enables and the writable mask
	function automatic logic [31:0] merge_write(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be,
		input logic [31:0] mask
	);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
		merge_write = (old_v & ~bm) | (new_v & bm);
	endfunction : merge_write

	// Address match against a base with don't-care bits
	function automatic logic io_match(
		input logic [15:0] addr,
		input logic [15:0] base,
		input logic [15:0] dc
	);
		io_match = ((addr & ~dc) == (base & ~dc));
	endfunction : io_match

	function automatic logic is_write(input logic [7:0] off);
		is_write = cfg_wr && (cfg_addr == off);
	endfunction : is_write

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evt_base_q <= RST_EVENT_BLOCK;
		end else if (is_write(OFF_EVENT_BLOCK_IO_BASE)) begin
			evt_base_q <= merge_write(evt_base_q, cfg_wdata, cfg_be,
				MASK_EVENT_BLOCK);
		end
	end

	// Straps are caught once, on the first edge after reset release
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken_q <= 1'b0;
			mem_id_q      <= 4'h0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			mem_id_q      <= strap_mem_id;
		end
	end

	// Drive bit 0 loads its strap once, at the capture; writes wait for the capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clk_drv_q <= RST_CLOCK_DRIVE;
		end else if (!strap_taken_q) begin
			clk_drv_q[0] <= strap_clk0_drive;
		end else if (is_write(OFF_BUS_CLOCK_DRIVE)) begin
			clk_drv_q <= merge_write(clk_drv_q, cfg_wdata, cfg_be,
				MASK_CLOCK_DRIVE);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			route_q <= RST_IRQ_ROUTING;
		end else if (is_write(OFF_CONTROL_IRQ_ROUTING)) begin
			route_q <= merge_write(route_q, cfg_wdata, cfg_be,
				MASK_IRQ_ROUTING);
		end
	end

	// Bits 31:29 and 0 are reserved; treated as read-zero here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			misc_q <= RST_MISC;
		end else if (is_write(OFF_MISC_POWER_DECODE)) begin
			misc_q <= merge_write(misc_q, cfg_wdata, cfg_be, MASK_MISC);
		end
	end

	// Write-once: the first write locks, whatever its byte enables
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ssid_q        <= 32'h0000_0000;
			ssid_locked_q <= 1'b0;
		end else if (is_write(OFF_SUBSYSTEM_ID) && !ssid_locked_q) begin
			ssid_q        <= merge_write(ssid_q, cfg_wdata, cfg_be,
				32'hFFFF_FFFF);
			ssid_locked_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata <= 32'h0000_0000;
		end else if (cfg_rd) begin
			case (cfg_addr)
				OFF_EVENT_BLOCK_IO_BASE: cfg_rdata <= evt_base_q;
				OFF_BUS_CLOCK_DRIVE:     cfg_rdata <= clk_drv_q;
				OFF_CONTROL_IRQ_ROUTING: cfg_rdata <= route_q;
				OFF_MISC_POWER_DECODE:   cfg_rdata <= misc_q
					| {24'h00_0000, mem_id_q[3], mem_id_q[2:1],
					mem_id_q[0], 4'h0};
				OFF_SUBSYSTEM_ID:        cfg_rdata <= ssid_q;
				default:                 cfg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			general_event_block_hit <= 1'b0;
			rtc_to_bus              <= 1'b0;
			pic_to_bus              <= 1'b0;
			pit_to_bus              <= 1'b0;
		end else begin
			general_event_block_hit <= io_req && evt_base_q[EVT_EN_BIT]
				&& io_addr[15:6] == evt_base_q[EVT_BASE_MSB:EVT_BASE_LSB];
			rtc_to_bus <= io_req && misc_q[RTC_OFF_BIT]
				&& io_match(io_addr, RTC_IO_BASE, RTC_IO_MASK);
			pic_to_bus <= io_req && misc_q[PIC_OFF_BIT]
				&& (io_match(io_addr, PIC_IO_BASE, PIC_IO_MASK)
				|| io_match(io_addr, PIC2_IO_BASE, PIC_IO_MASK));
			pit_to_bus <= io_req && misc_q[PIT_OFF_BIT]
				&& io_match(io_addr, PIT_IO_BASE, PIT_IO_MASK);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clk_out1_on       <= 1'b1;
			clk_out2_on       <= 1'b1;
			clk_drive_q       <= RST_CLOCK_DRIVE[5:0];
			bus_clk_full_rate <= 1'b1;
		end else begin
			clk_out1_on <= clk_drv_q[CLK_OUT1_EN_BIT];
			clk_out2_on <= clk_drv_q[CLK_OUT2_EN_BIT];
			clk_drive_q <= clk_drv_q[5:0];
			bus_clk_full_rate <= !clock_fuse_blown
				|| misc_q[FREQ_SEL_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			control_irq_lines <= 7'h00;
		end else begin
			case (irq_route_t'(route_q[2:0]))
				ROUTE_IRQ9:  control_irq_lines <= {6'h00, system_control_interrupt};
				ROUTE_IRQ10: control_irq_lines <= {5'h00, system_control_interrupt, 1'b0};
				ROUTE_IRQ11: control_irq_lines <= {4'h0, system_control_interrupt, 2'h0};
				ROUTE_IRQ20: control_irq_lines <= {3'h0, system_control_interrupt, 3'h0};
				ROUTE_IRQ21: control_irq_lines <= {2'h0, system_control_interrupt, 4'h0};
				ROUTE_IRQ22: control_irq_lines <= {1'b0, system_control_interrupt, 5'h00};
				ROUTE_IRQ23: control_irq_lines <= {system_control_interrupt, 6'h00};
				default:     control_irq_lines <= 7'h00;
			endcase
		end
	end

	assign blk_tick     = misc_q[BLK_TICK_LSB +: NUM_SLEEP];
	assign blk_irq      = misc_q[BLK_IRQ_LSB +: NUM_SLEEP];
	assign tick_blocked = |(blk_tick & sleep_state);
	assign irq_blocking = |(blk_irq & sleep_state);
	// Gather only where ticks are blocked; break ends the hold
	assign gather_en    = tick_blocked;

	tick_gatherer u_gather (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.gather_en   (gather_en),
		.tick_target (misc_q[TICK_CNT_LSB +: 4]),
		.tick_in     (timer_tick),
		.break_pulse (break_pulse),
		.tick_count  ()
	);

	// Blocking states seen last cycle, to spot a fresh entry
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_state_q <= 5'h00;
		end else begin
			irq_state_q <= blk_irq & sleep_state;
		end
	end

	assign irq_entry   = |(blk_irq & sleep_state & ~irq_state_q);
	// Release: one tick, or the break when ticks are being gathered
	assign irq_release = tick_blocked ? break_pulse : timer_tick;

	// Hold is armed only on entry, so one release lasts the whole stay
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_hold_q <= 1'b0;
		end else if (!irq_blocking) begin
			irq_hold_q <= 1'b0;
		end else if (irq_entry) begin
			irq_hold_q <= 1'b1;
		end else if (irq_release) begin
			irq_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_tick_out <= 1'b0;
		end else begin
			timer_tick_out <= timer_tick && !tick_blocked;
		end
	end

	// Entry term covers the cycle before the hold flop is set
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= irq_pending
				&& !(irq_blocking && (irq_hold_q || irq_entry));
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			break_event <= 1'b0;
		end else begin
			break_event <= break_pulse;
		end
	end

endmodule : lpc_bridge_misc_config_regs

// File: tb/lpc_cfg_sva.sv
/* Port checker for the bridge miscellaneous configuration bank.
 * Assumes one clock clk_sys and the async active-low rst_n. */
`timescale 1ns/1ps
module lpc_cfg_sva (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Config port
	input wire logic        cfg_wr,
	input wire logic        cfg_rd,
	input wire logic [31:0] cfg_rdata,
	// Decode
	input wire logic        io_req,
	input wire logic [15:0] io_addr,
	input wire logic        general_event_block_hit,
	input wire logic        rtc_to_bus,
	input wire logic        pic_to_bus,
	input wire logic        pit_to_bus,
	// Clocks and interrupts
	input wire logic        clk_out1_on,
	input wire logic        clock_fuse_blown,
	input wire logic        bus_clk_full_rate,
	input wire logic        system_control_interrupt,
	input wire logic [6:0]  control_irq_lines,
	// Power management
	input wire logic        timer_tick,
	input wire logic        timer_tick_out,
	input wire logic        break_event
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_hit_needs_req:
	assert property (general_event_block_hit |-> $past(io_req))
		else $error("event block hit without request");
	a_rtc_window:
	assert property (rtc_to_bus |-> $past(io_addr[15:3]) == 13'h000E)
		else $error("clock redirect outside its window");
	a_pit_window:
	assert property (pit_to_bus |-> $past(io_req) && $past(io_addr[15:2]) == 14'h0010)
		else $error("timer redirect outside its window");
	a_irq_one_line:
	assert property ($onehot0(control_irq_lines))
		else $error("control interrupt on several lines");
	a_irq_has_src:
	assert property (|control_irq_lines |-> $past(system_control_interrupt))
		else $error("control interrupt line without source");
	a_fuse_full_rate:
	assert property (!$past(clock_fuse_blown) |-> bus_clk_full_rate)
		else $error("half rate with fuse intact");
	a_break_after_tick:
	assert property (break_event |-> $past(timer_tick, 2))
		else $error("break event not two cycles after a tick");
	a_tick_out_cause:
	assert property (timer_tick_out |-> $past(timer_tick))
		else $error("tick passed without a tick");
	a_rdata_holds:
	assert property (!$past(cfg_rd) |-> $stable(cfg_rdata))
		else $error("read data moved without a read");
	a_clk_en_holds:
	assert property (!$past(cfg_wr, 2) |-> $stable(clk_out1_on))
		else $error("clock enable moved without a write");

	c_break: cover property (break_event);
	c_hit: cover property (general_event_block_hit);
	c_pic: cover property (pic_to_bus);
endmodule : lpc_cfg_sva

bind lpc_bridge_misc_config_regs lpc_cfg_sva lpc_cfg_sva_i (.*);

// File: tb/lpc_bridge_misc_config_regs_test.sv
/* Bench for the configuration bank: register table, then decode, clock,
 * routing and sleep-state cases. Assumes the checker binds itself. */
`timescale 1ns/1ps
module lpc_bridge_misc_config_regs_test import lpc_cfg_pkg::*;;
	logic        clk_sys, rst_n, cfg_wr, cfg_rd, io_req;
	logic        strap_clk0_drive, clock_fuse_blown, irq_pending;
	logic        system_control_interrupt, timer_tick;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be, strap_mem_id;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [15:0] io_addr;
	logic [4:0]  sleep_state;
	logic        general_event_block_hit, rtc_to_bus, pic_to_bus, pit_to_bus;
	logic        clk_out1_on, clk_out2_on, bus_clk_full_rate;
	logic        timer_tick_out, irq_out, break_event;
	logic [5:0]  clk_drive_q;
	logic [6:0]  control_irq_lines;
	int          miscompares, total_checks, i, n, m;
	typedef struct {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	// Straps give 0xA0 in the misc strap field
	row_t rows [9] = '{
		'{8'h4C, 32'hFFFF_FFFF, 32'h8000_FFC0},
		'{8'h54, 32'hFFFF_FFFF, 32'h0006_003F},
		'{8'h54, 32'h0000_0000, 32'h0000_0000},
		'{8'h58, 32'hFFFF_FFFF, 32'h0000_0007},
		'{8'h5C, 32'hFFFF_FFFF, 32'h1F1F_1FAE},
		'{8'h5C, 32'h0000_0000, 32'h0000_00A0},
		'{8'h40, 32'hFFFF_FFFF, 32'h0000_0000},
		'{8'h2C, 32'h1234_5678, 32'h1234_5678},
		'{8'h2C, 32'hFFFF_FFFF, 32'h1234_5678}
	};

	lpc_bridge_misc_config_regs lpc_bridge_misc_config_regs_i (.*);

	always #12.5 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b = 4'hF);
		@(negedge clk_sys);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_be = b;
		cfg_wdata = d;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
		cfg_wdata = ~d;
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk_sys);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk_sys);
		cfg_rd = 1'b0;
		chk(cfg_rdata, e);
	endtask : rdc

	task automatic io(input logic [15:0] a, input logic [3:0] e);
		@(negedge clk_sys);
		io_req = 1'b1;
		io_addr = a;
		@(negedge clk_sys);
		io_req = 1'b0;
		io_addr = ~a;
		chk(32'({general_event_block_hit, rtc_to_bus, pic_to_bus,
			pit_to_bus}), 32'(e));
	endtask : io

	task automatic tick;
		@(negedge clk_sys);
		timer_tick = 1'b1;
		@(negedge clk_sys);
		timer_tick = 1'b0;
	endtask : tick

	// Ticks every per cycles; n counts breaks, m passed ticks
	task automatic burst(input int per, input int len);
		n = 0;
		m = 0;
		for (int k = 0; k < len; k++) begin
			@(negedge clk_sys);
			n += int'(break_event);
			m += int'(timer_tick_out);
			timer_tick = (k % per == 0);
		end
		@(negedge clk_sys);
		timer_tick = 1'b0;
	endtask : burst

	task automatic conclude;
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	initial begin
		#100us;
		miscompares++;
		conclude();
	end

	initial begin
		{clk_sys, rst_n, cfg_wr, cfg_rd, io_req, timer_tick} = '0;
		{clock_fuse_blown, sleep_state, cfg_addr, cfg_be, io_addr} = '0;
		{cfg_wdata, miscompares, total_checks} = '0;
		{strap_clk0_drive, system_control_interrupt, irq_pending} = '1;
		strap_mem_id = 4'hA;
		cyc(16);
		rst_n = 1'b1;
		cyc(2);
		rdc(8'h4C, 32'h0000_0000);
		rdc(8'h54, 32'h0006_003F);
		rdc(8'h58, 32'h0000_0003);
		rdc(8'h5C, 32'h0000_00A0);
		chk(32'({clk_out1_on, clk_out2_on, bus_clk_full_rate}), 32'h7);
		chk(32'(control_irq_lines), 32'h0);
		for (i = 0; i < 9; i++) begin
			wr(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e);
		end
		// Partial byte enables only touch their own byte
		wr(8'h4C, 32'h0);
		wr(8'h4C, 32'hFFFF_FFFF, 4'h2);
		rdc(8'h4C, 32'h0000_FF00);
		wr(8'h4C, 32'h8000_1240);
		io(16'h1240, 4'h8);
		io(16'h127F, 4'h8);
		io(16'h1280, 4'h0);
		io(16'h0070, 4'h0);
		wr(8'h4C, 32'h0000_1240);
		io(16'h1240, 4'h0);
		wr(8'h5C, 32'h0000_000E);
		io(16'h0077, 4'h4);
		io(16'h00A1, 4'h2);
		io(16'h0043, 4'h1);
		io(16'h0044, 4'h0);
		wr(8'h54, 32'h0004_0015);
		cyc(2);
		chk(32'({clk_out2_on, clk_out1_on, clk_drive_q}), 32'h95);
		wr(8'h5C, 32'h0);
		cyc(2);
		chk(32'(bus_clk_full_rate), 32'h1);
		clock_fuse_blown = 1'b1;
		cyc(2);
		chk(32'(bus_clk_full_rate), 32'h0);
		wr(8'h5C, 32'h1000_0000);
		cyc(2);
		chk(32'(bus_clk_full_rate), 32'h1);
		for (i = 0; i < 8; i++) begin
			wr(8'h58, 32'(i));
			cyc(2);
			chk(32'(control_irq_lines), i == 3 ? 0 : 1 << (i - (i > 3)));
		end
		system_control_interrupt = 1'b0;
		cyc(2);
		chk(32'(control_irq_lines), 32'h0);
		sleep_state = 5'h01;
		tick();
		chk(32'(timer_tick_out), 32'h1);
		wr(8'h5C, 32'h0201_0000);
		burst(4, 12);
		chk(32'(n), 32'h1);
		chk(32'(m), 32'h0);
		wr(8'h5C, 32'h0001_0000);
		burst(2, 40);
		chk(32'(n), 32'h1);
		wr(8'h5C, 32'h0000_0100);
		sleep_state = 5'h00;
		cyc(3);
		chk(32'(irq_out), 32'h1);
		sleep_state = 5'h01;
		cyc(3);
		chk(32'(irq_out), 32'h0);
		tick();
		cyc(2);
		chk(32'(irq_out), 32'h1);
		wr(8'h5C, 32'h0201_0100);
		sleep_state = 5'h00;
		cyc(2);
		sleep_state = 5'h01;
		cyc(3);
		tick();
		cyc(2);
		chk(32'(irq_out), 32'h0);
		tick();
		cyc(4);
		chk(32'(irq_out), 32'h1);
		conclude();
	end
endmodule : lpc_bridge_misc_config_regs_test
